// ---- core/toff_status_regs.v ----
// How it works
// - Each turn-off time is a 16-bit word: signed 11-bit mantissa, signed 5-bit exponent.
// - Exponent is always zero, so the mantissa is the time in milliseconds.
// - Only 0 to 127 ms in 1 ms steps are accepted.
// - Illegal timing writes are dropped, old value kept, and an error is flagged.
// - Delay setting times stop request until energy delivery to the output ends.
// - Delay setting restores to 0000h, zero milliseconds.
// - Fall setting times end of delay until the voltage target reaches zero.
// - Fall setting restores to 0005h, five milliseconds.
// - Controlled fall ramp only when the output stage can sink enough current.
// - Warning limit bounds power-down time until output drops below one eighth.
// - Warning limit restores to 003Ch, sixty milliseconds.
// - Summary byte command returns one read-only byte of critical faults.
// - Byte bit 7 flags a fault declared because the device was busy.
// - Byte bit 6 is set whenever the output delivers no power.
// - Byte bits 5, 4, 3: output overvoltage, output overcurrent, input undervoltage.
// - Byte bit 2 any temperature event; bit 1 communication, memory or logic fault.
// - Byte bit 0 flags any fault or warning not shown in bits 7 to 1.
// - Summary word returns two bytes; its low byte is the summary byte storage.
// - Word high bit 7 any output voltage event; bit 6 output current or power.
// - Word high bit 5 any input event; bit 4 any vendor-specific event.
// - Word high bit 3 set while power good is negated; bits 2..0 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "toff_status_map.vh"

module toff_status_regs #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS
) (
  // Clock and reset
  input wire core_clk_i,
  input wire arst_n_i,
  // Command port from the bus transaction layer
  input wire [7:0] cmd_code_i,
  input wire cmd_wr_i,
  input wire cmd_rd_i,
  input wire [15:0] cmd_wdata_i,
  output reg [15:0] cmd_rdata_o,
  output reg cmd_rvalid_o,
  output reg cmd_err_o,
  // Sequencing side
  input wire run_i,
  input wire [15:0] vout_prog_i,
  input wire sink_capable_i,
  input wire vout_below_eighth_i,
  output reg power_stage_en_o,
  output reg fall_ramp_active_o,
  output reg [15:0] vout_target_o,
  output reg toff_max_warn_o,
  // Detailed fault flags from fault detection
  input wire busy_fault_i,
  input wire output_overvoltage_flag_i,
  input wire vout_ov_warn_i,
  input wire vout_uv_warn_i,
  input wire vout_uv_fault_i,
  input wire vout_max_min_i,
  input wire ton_max_fault_i,
  input wire output_overcurrent_flag_i,
  input wire iout_oc_warn_i,
  input wire vin_ov_fault_i,
  input wire input_undervoltage_flag_i,
  input wire vin_uv_warn_i,
  input wire iin_oc_warn_i,
  input wire ot_fault_i,
  input wire ot_warn_i,
  input wire [3:0] comm_memory_logic_flag_i,
  input wire [3:0] mfr_fault_i,
  input wire power_good_i,
  input wire clear_faults_i,
  // Summary outputs
  output reg [15:0] fault_summary_word_o,
  output reg bad_cmd_flag_o,
  output reg bad_data_flag_o
);

  // Turn-off sequencer states
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_ON = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_DIV = 3'h3;
  localparam [2:0] ST_FALL = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  // Time word is legal when exponent is zero and mantissa within 0..127
  function legal_time;
    input [15:0] w;
    begin
      legal_time = (w[`TIME_EXP_MSB:`TIME_EXP_LSB] == `TIME_EXP_FIXED) &&
        (w[`TIME_MANT_MSB:`TIME_LEGAL_MSB+1] == 4'h0);
    end
  endfunction

  // Command decode, used by the error flags for both writes and reads
  function is_timing_cmd;
    input [7:0] c;
    begin
      is_timing_cmd = (c == `CMD_TURN_OFF_DELAY_TIME) || (c == `CMD_TURN_OFF_FALL_TIME) ||
        (c == `CMD_TURN_OFF_WARN_LIMIT);
    end
  endfunction

  reg [1:0] rst_sync_r;
  wire rst_n;
  reg [15:0] turn_off_delay_time_r;
  reg [15:0] turn_off_fall_time_r;
  reg [15:0] turn_off_time_warning_limit_r;
  reg [2:0] state_r;
  reg [16:0] ms_cnt_r;
  reg ms_tick_r;
  reg [6:0] phase_ms_r;
  reg [7:0] warn_ms_r;
  reg warn_run_r;
  reg [15:0] div_rem_r;
  reg [15:0] div_quo_r;
  reg [4:0] div_bit_r;
  reg [16:0] div_trial;
  wire [7:0] fault_summary_byte;
  wire cml_any;
  wire write_ok;

  // Reset release through two flip-flops
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  assign write_ok = legal_time(cmd_wdata_i);

  // Timing settings write path with range check
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      turn_off_delay_time_r <= `RST_TURN_OFF_DELAY_TIME;
      turn_off_fall_time_r <= `RST_TURN_OFF_FALL_TIME;
      turn_off_time_warning_limit_r <= `RST_TURN_OFF_WARN_LIMIT;
    end else if (cmd_wr_i && write_ok) begin
      case (cmd_code_i)
        `CMD_TURN_OFF_DELAY_TIME: turn_off_delay_time_r <= cmd_wdata_i;
        `CMD_TURN_OFF_FALL_TIME: turn_off_fall_time_r <= cmd_wdata_i;
        `CMD_TURN_OFF_WARN_LIMIT: turn_off_time_warning_limit_r <= cmd_wdata_i;
        default: turn_off_delay_time_r <= turn_off_delay_time_r;
      endcase
    end
  end

  // Sticky command and data error flags; a new error beats the clear
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bad_cmd_flag_o <= 1'b0;
      bad_data_flag_o <= 1'b0;
      cmd_err_o <= 1'b0;
    end else begin
      cmd_err_o <= 1'b0;
      if (cmd_wr_i && !is_timing_cmd(cmd_code_i)) begin
        bad_cmd_flag_o <= 1'b1;
        cmd_err_o <= 1'b1;
      end else if (cmd_rd_i && !is_timing_cmd(cmd_code_i) &&
                   cmd_code_i != `CMD_FAULT_SUMMARY_BYTE &&
                   cmd_code_i != `CMD_FAULT_SUMMARY_WORD) begin
        bad_cmd_flag_o <= 1'b1;
        cmd_err_o <= 1'b1;
      end else if (clear_faults_i) begin
        bad_cmd_flag_o <= 1'b0;
      end
      if (cmd_wr_i && is_timing_cmd(cmd_code_i) && !write_ok) begin
        bad_data_flag_o <= 1'b1;
        cmd_err_o <= 1'b1;
      end else if (clear_faults_i) begin
        bad_data_flag_o <= 1'b0;
      end
    end
  end

  // Millisecond time base, held at zero in ST_OFF and ST_ON, so it restarts at the stop request
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 17'h00000;
      ms_tick_r <= 1'b0;
    end else if (state_r == ST_ON || state_r == ST_OFF) begin
      ms_cnt_r <= 17'h00000;
      ms_tick_r <= 1'b0;
    end else if (ms_cnt_r == CYCLES_PER_MS[16:0] - 17'h00001) begin
      ms_cnt_r <= 17'h00000;
      ms_tick_r <= 1'b1;
    end else begin
      ms_cnt_r <= ms_cnt_r + 17'h00001;
      ms_tick_r <= 1'b0;
    end
  end

  // One step of the serial divider for the fall ramp slope
  always @* begin
    div_trial = {div_rem_r, div_quo_r[15]} - {10'h000, turn_off_fall_time_r[6:0]};
  end

  // Turn-off sequencer: delay, then fall ramp, then off
  // The 17-cycle divide must be shorter than one millisecond
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      phase_ms_r <= 7'h00;
      power_stage_en_o <= 1'b0;
      fall_ramp_active_o <= 1'b0;
      vout_target_o <= 16'h0000;
      div_rem_r <= 16'h0000;
      div_quo_r <= 16'h0000;
      div_bit_r <= 5'h00;
    end else begin
      case (state_r)
        ST_OFF: begin
          vout_target_o <= 16'h0000;
          if (run_i) begin
            state_r <= ST_ON;
            power_stage_en_o <= 1'b1;
          end
        end
        ST_ON: begin
          vout_target_o <= vout_prog_i;
          if (!run_i) begin
            state_r <= ST_DELAY;
            phase_ms_r <= 7'h00;
          end
        end
        ST_DELAY: begin
          if (phase_ms_r == turn_off_delay_time_r[6:0]) begin
            power_stage_en_o <= 1'b0;
            phase_ms_r <= 7'h00;
            if (sink_capable_i && turn_off_fall_time_r[6:0] != 7'h00) begin
              state_r <= ST_DIV;
              div_rem_r <= 16'h0000;
              div_quo_r <= vout_target_o;
              div_bit_r <= 5'h10;
            end else begin
              state_r <= ST_DONE;
              vout_target_o <= 16'h0000;
            end
          end else if (ms_tick_r) begin
            phase_ms_r <= phase_ms_r + 7'h01;
          end
        end
        ST_DIV: begin
          if (div_bit_r == 5'h00) begin
            state_r <= ST_FALL;
            fall_ramp_active_o <= 1'b1;
          end else begin
            div_bit_r <= div_bit_r - 5'h01;
            if (!div_trial[16]) begin
              div_rem_r <= div_trial[15:0];
              div_quo_r <= {div_quo_r[14:0], 1'b1};
            end else begin
              div_rem_r <= {div_rem_r[14:0], div_quo_r[15]};
              div_quo_r <= {div_quo_r[14:0], 1'b0};
            end
          end
        end
        ST_FALL: begin
          if (ms_tick_r) begin
            phase_ms_r <= phase_ms_r + 7'h01;
            if (phase_ms_r + 7'h01 == turn_off_fall_time_r[6:0] ||
                vout_target_o < div_quo_r) begin
              vout_target_o <= 16'h0000;
              fall_ramp_active_o <= 1'b0;
              state_r <= ST_DONE;
            end else begin
              vout_target_o <= vout_target_o - div_quo_r;
            end
          end
        end
        ST_DONE: begin
          if (!warn_run_r) begin
            state_r <= ST_OFF;
          end
        end
        default: begin
          state_r <= ST_OFF;
          power_stage_en_o <= 1'b0;
          fall_ramp_active_o <= 1'b0;
        end
      endcase
    end
  end

  // Power-down watchdog against the warning limit; warning is sticky
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      warn_run_r <= 1'b0;
      warn_ms_r <= 8'h00;
      toff_max_warn_o <= 1'b0;
    end else begin
      if (state_r == ST_DELAY && phase_ms_r == turn_off_delay_time_r[6:0]) begin
        warn_run_r <= 1'b1;
        warn_ms_r <= 8'h00;
      end else if (warn_run_r) begin
        if (vout_below_eighth_i || run_i) begin
          warn_run_r <= 1'b0;
        end else if (warn_ms_r[6:0] == turn_off_time_warning_limit_r[6:0]) begin
          warn_run_r <= 1'b0;
        end else if (ms_tick_r) begin
          warn_ms_r <= warn_ms_r + 8'h01;
        end
      end
      if (warn_run_r && !vout_below_eighth_i && !run_i &&
          warn_ms_r[6:0] == turn_off_time_warning_limit_r[6:0]) begin
        toff_max_warn_o <= 1'b1;
      end else if (clear_faults_i) begin
        toff_max_warn_o <= 1'b0;
      end
    end
  end

  // Category summaries as ORs of detailed flags
  assign cml_any = (|comm_memory_logic_flag_i) | bad_cmd_flag_o | bad_data_flag_o;
  assign fault_summary_byte = fault_summary_word_o[7:0];

  // Summary word storage; low byte is the summary byte itself
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_summary_word_o <= 16'h0000;
    end else begin
      fault_summary_word_o[`SB_BUSY] <= busy_fault_i;
      fault_summary_word_o[`SB_OFF] <= !power_stage_en_o;
      fault_summary_word_o[`SB_VOUT_OV] <= output_overvoltage_flag_i;
      fault_summary_word_o[`SB_IOUT_OC] <= output_overcurrent_flag_i;
      fault_summary_word_o[`SB_VIN_UV] <= input_undervoltage_flag_i;
      fault_summary_word_o[`SB_TEMP] <= ot_fault_i | ot_warn_i;
      fault_summary_word_o[`SB_CML] <= cml_any;
      fault_summary_word_o[`SB_OTHER] <= vout_ov_warn_i | vout_uv_warn_i | vout_uv_fault_i |
        vout_max_min_i | ton_max_fault_i | toff_max_warn_o | iout_oc_warn_i | vin_ov_fault_i |
        vin_uv_warn_i | iin_oc_warn_i | (|mfr_fault_i);
      fault_summary_word_o[8+`SW_VOUT] <= output_overvoltage_flag_i | vout_ov_warn_i |
        vout_uv_warn_i | vout_uv_fault_i | vout_max_min_i | ton_max_fault_i |
        toff_max_warn_o;
      fault_summary_word_o[8+`SW_IOUT] <= output_overcurrent_flag_i | iout_oc_warn_i;
      fault_summary_word_o[8+`SW_INPUT] <= vin_ov_fault_i | input_undervoltage_flag_i |
        vin_uv_warn_i | iin_oc_warn_i;
      fault_summary_word_o[8+`SW_MFR] <= |mfr_fault_i;
      fault_summary_word_o[8+`SW_PG_N] <= !power_good_i;
      fault_summary_word_o[10:8] <= 3'h0;
    end
  end

  // Read path: answer one cycle after the read strobe
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata_o <= 16'h0000;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_rd_i;
      if (cmd_rd_i) begin
        case (cmd_code_i)
          `CMD_TURN_OFF_DELAY_TIME: cmd_rdata_o <= turn_off_delay_time_r;
          `CMD_TURN_OFF_FALL_TIME: cmd_rdata_o <= turn_off_fall_time_r;
          `CMD_TURN_OFF_WARN_LIMIT: cmd_rdata_o <= turn_off_time_warning_limit_r;
          `CMD_FAULT_SUMMARY_BYTE: cmd_rdata_o <= {8'h00, fault_summary_byte};
          `CMD_FAULT_SUMMARY_WORD: cmd_rdata_o <= fault_summary_word_o;
          default: cmd_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- core/toff_status_map.vh ----
`ifndef TOFF_STATUS_MAP_VH
`define TOFF_STATUS_MAP_VH

// Command codes
`define CMD_TURN_OFF_DELAY_TIME 8'h64
`define CMD_TURN_OFF_FALL_TIME 8'h65
`define CMD_TURN_OFF_WARN_LIMIT 8'h66
`define CMD_FAULT_SUMMARY_BYTE 8'h78
`define CMD_FAULT_SUMMARY_WORD 8'h79

// Restore values of the timing settings
`define RST_TURN_OFF_DELAY_TIME 16'h0000
`define RST_TURN_OFF_FALL_TIME 16'h0005
`define RST_TURN_OFF_WARN_LIMIT 16'h003C

// Timing word layout: mantissa [10:0], exponent [15:11]
`define TIME_MANT_MSB 10
`define TIME_EXP_LSB 11
`define TIME_EXP_MSB 15
`define TIME_EXP_FIXED 5'h00
// Legal range 0..127 ms: bits above 6 must all be zero
`define TIME_LEGAL_MSB 6
`define TIME_MAX_MS 7'h7F

// Summary byte bit positions
`define SB_BUSY 7
`define SB_OFF 6
`define SB_VOUT_OV 5
`define SB_IOUT_OC 4
`define SB_VIN_UV 3
`define SB_TEMP 2
`define SB_CML 1
`define SB_OTHER 0
// Summary word high byte bit positions
`define SW_VOUT 7
`define SW_IOUT 6
`define SW_INPUT 5
`define SW_MFR 4
`define SW_PG_N 3

// Timing: one millisecond at the core clock rate
`define CORE_CLK_KHZ 100000
`define TIME_UNIT_MS 1
`define CYCLES_PER_MS (`CORE_CLK_KHZ * `TIME_UNIT_MS)

`endif

// ---- tb/toff_status_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module toff_status_chk (
  // Clock, reset and command port
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic cmd_rvalid_o,
  input wire logic cmd_err_o,
  // Sequencing and summary
  input wire logic run_i,
  input wire logic sink_capable_i,
  input wire logic vout_below_eighth_i,
  input wire logic power_stage_en_o,
  input wire logic fall_ramp_active_o,
  input wire logic toff_max_warn_o,
  input wire logic power_good_i,
  input wire logic [15:0] fault_summary_word_o,
  input wire logic bad_cmd_flag_o,
  input wire logic bad_data_flag_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [1:0] live_cnt_r;
  wire live = live_cnt_r == 2'h3;
  wire time_code = cmd_code_i >= 8'h64 && cmd_code_i <= 8'h66;
  wire time_bad = cmd_wdata_i[15:7] != 9'h000;
  // Summary is trusted only once the internal reset has let go
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) live_cnt_r <= 2'h0;
    else if (!live) live_cnt_r <= live_cnt_r + 2'h1;
  end
  // Command port
  a_read_answer: assert property (cmd_rd_i |=> cmd_rvalid_o)
    else $error("read not answered");
  a_answer_cause: assert property (cmd_rvalid_o |-> $past(cmd_rd_i))
    else $error("answer without read");
  a_bad_time_err: assert property (cmd_wr_i && time_code && time_bad
    |=> cmd_err_o && bad_data_flag_o) else $error("bad time not refused");
  a_good_time_ok: assert property (cmd_wr_i && time_code && !time_bad
    |=> !cmd_err_o) else $error("legal time refused");
  a_ro_write_err: assert property (cmd_wr_i && cmd_code_i[7:1] == 7'h3C
    |=> cmd_err_o && bad_cmd_flag_o) else $error("summary write not refused");
  // Summary bits
  a_off_bit_follows: assert property (live
    |-> fault_summary_word_o[6] == !$past(power_stage_en_o)) else $error("off bit wrong");
  a_pg_bit_follows: assert property (live
    |-> fault_summary_word_o[11] == !$past(power_good_i)) else $error("pg bit wrong");
  a_unimpl_zero: assert property (fault_summary_word_o[10:8] == 3'h0)
    else $error("unimplemented bits set");
  // Sequencer
  a_ramp_needs_sink: assert property (fall_ramp_active_o |-> sink_capable_i)
    else $error("ramp without sink");
  a_warn_cause: assert property ($rose(toff_max_warn_o)
    |-> !$past(vout_below_eighth_i) && !$past(run_i)) else $error("warning without cause");
  c_ramp: cover property ($rose(fall_ramp_active_o));
  c_warn: cover property ($rose(toff_max_warn_o));
  c_err: cover property (cmd_err_o);
endmodule
bind toff_status_regs toff_status_chk u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd_code_i(cmd_code_i),
  .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_wdata_i(cmd_wdata_i),
  .cmd_rvalid_o(cmd_rvalid_o), .cmd_err_o(cmd_err_o), .run_i(run_i),
  .sink_capable_i(sink_capable_i), .vout_below_eighth_i(vout_below_eighth_i),
  .power_stage_en_o(power_stage_en_o), .fall_ramp_active_o(fall_ramp_active_o),
  .toff_max_warn_o(toff_max_warn_o), .power_good_i(power_good_i),
  .fault_summary_word_o(fault_summary_word_o), .bad_cmd_flag_o(bad_cmd_flag_o),
  .bad_data_flag_o(bad_data_flag_o)
);
`default_nettype wire

// ---- tb/output_plant.sv ----
`timescale 1ns/1ps
`default_nettype none
module output_plant (
  // Clock
  input wire logic core_clk_i,
  // From the regulator
  input wire logic [15:0] vout_target_i,
  input wire logic [15:0] vout_prog_i,
  input wire logic stuck_i,
  // To the regulator
  output logic vout_below_eighth_o
);
  // Output trails the target; stuck models a load holding it up
  always @(posedge core_clk_i) begin
    vout_below_eighth_o <= !stuck_i && (vout_target_i < (vout_prog_i >> 3));
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_i, arst_n_i, cmd_wr_i, cmd_rd_i, run_i, sink, pg, clr, stuck, ramp_seen;
  logic [7:0] code;
  logic [15:0] wdata;
  logic [14:0] fl;
  logic [3:0] comm_memory_logic_flag, mfr;
  wire [15:0] rdata, target, word;
  wire rvalid, err, below, en, ramp, warn, bcmd, bdata;
  wire [3:0] obs = {warn, target == 16'h0000, ramp, en};
  int fail_count, total_checks, cyc, n, i;
  logic [15:0] exp_tab [0:16] = '{16'h00C0, 16'h8060, 16'h8041, 16'h8041, 16'h8041,
    16'h8041, 16'h8041, 16'h4050, 16'h4041, 16'h2041, 16'h2048, 16'h2041, 16'h2041,
    16'h0044, 16'h0044, 16'h0042, 16'h1041};
  toff_status_regs #(.CYCLES_PER_MS(20)) i_dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd_code_i(code), .cmd_wr_i(cmd_wr_i),
    .cmd_rd_i(cmd_rd_i), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata), .cmd_rvalid_o(rvalid),
    .cmd_err_o(err), .run_i(run_i), .vout_prog_i(16'h0400), .sink_capable_i(sink),
    .vout_below_eighth_i(below), .power_stage_en_o(en), .fall_ramp_active_o(ramp),
    .vout_target_o(target), .toff_max_warn_o(warn), .busy_fault_i(fl[0]),
    .output_overvoltage_flag_i(fl[1]), .vout_ov_warn_i(fl[2]), .vout_uv_warn_i(fl[3]),
    .vout_uv_fault_i(fl[4]), .vout_max_min_i(fl[5]), .ton_max_fault_i(fl[6]),
    .output_overcurrent_flag_i(fl[7]), .iout_oc_warn_i(fl[8]), .vin_ov_fault_i(fl[9]),
    .input_undervoltage_flag_i(fl[10]), .vin_uv_warn_i(fl[11]), .iin_oc_warn_i(fl[12]),
    .ot_fault_i(fl[13]), .ot_warn_i(fl[14]), .comm_memory_logic_flag_i(comm_memory_logic_flag),
    .mfr_fault_i(mfr), .power_good_i(pg), .clear_faults_i(clr),
    .fault_summary_word_o(word), .bad_cmd_flag_o(bcmd), .bad_data_flag_o(bdata)
  );
  output_plant i_plant (.core_clk_i(core_clk_i), .vout_target_i(target),
    .vout_prog_i(16'h0400), .stuck_i(stuck), .vout_below_eighth_o(below));
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rng(input string nm, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask
  // One read: strobe for a cycle, answer stands the cycle after
  task rd_chk(input logic [7:0] c, input logic [15:0] e);
    @(posedge core_clk_i) #1;
    code = c;
    cmd_rd_i = 1'b1;
    @(posedge core_clk_i) #1;
    cmd_rd_i = 1'b0;
    chk($sformatf("rvalid %h", c), 16'h0001, {15'h0000, rvalid});
    chk($sformatf("read %h", c), e, rdata);
  endtask
  task wr_chk(input logic [7:0] c, input logic [15:0] d, input logic e);
    @(posedge core_clk_i) #1;
    code = c;
    wdata = d;
    cmd_wr_i = 1'b1;
    @(posedge core_clk_i) #1;
    cmd_wr_i = 1'b0;
    chk($sformatf("err %h", c), {15'h0000, e}, {15'h0000, err});
  endtask
  task pulse_clear;
    @(posedge core_clk_i) #1;
    clr = 1'b1;
    @(posedge core_clk_i) #1;
    clr = 1'b0;
  endtask
  // Count edges until an observed output reaches a level
  task wait_obs(input int s, input logic v, input int lim);
    n = 0;
    while (obs[s] !== v && n < lim) begin
      @(posedge core_clk_i) #1;
      ramp_seen = ramp_seen | ramp;
      n++;
    end
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Cycle ceiling
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    {arst_n_i, cmd_wr_i, cmd_rd_i, run_i, pg, clr, stuck, ramp_seen} = 8'h00;
    {code, wdata, fl, comm_memory_logic_flag, mfr} = 47'h0;
    sink = 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1 arst_n_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    rd_chk(8'h64, 16'h0000);
    rd_chk(8'h65, 16'h0005);
    rd_chk(8'h66, 16'h003C);
    rd_chk(8'h78, 16'h0040);
    rd_chk(8'h79, 16'h0840);
    pg = 1'b1;
    $display("test reset_values done");
    for (i = 0; i < 17; i++) begin
      fl = (i < 15) ? 15'h0001 << i : 15'h0000;
      comm_memory_logic_flag = (i == 15) ? 4'h8 : 4'h0;
      mfr = (i == 16) ? 4'h4 : 4'h0;
      rd_chk(8'h79, exp_tab[i]);
      rd_chk(8'h78, {8'h00, exp_tab[i][7:0]});
    end
    {fl, comm_memory_logic_flag, mfr} = 23'h0;
    $display("test summary_map done");
    for (i = 0; i < 3; i++) begin
      wr_chk(8'h64 + i[7:0], 16'h007F, 1'b0);
      rd_chk(8'h64 + i[7:0], 16'h007F);
      wr_chk(8'h64 + i[7:0], 16'h0080, 1'b1);
      wr_chk(8'h64 + i[7:0], 16'h0801, 1'b1);
      rd_chk(8'h64 + i[7:0], 16'h007F);
    end
    wr_chk(8'h78, 16'h0000, 1'b1);
    wr_chk(8'h79, 16'h0000, 1'b1);
    rd_chk(8'h78, 16'h0042);
    chk("bad flags", 16'h0003, {14'h0000, bcmd, bdata});
    pulse_clear;
    rd_chk(8'h78, 16'h0040);
    chk("bad flags clear", 16'h0000, {14'h0000, bcmd, bdata});
    $display("test timing_writes done");
    wr_chk(8'h64, 16'h0002, 1'b0);
    wr_chk(8'h65, 16'h0004, 1'b0);
    wr_chk(8'h66, 16'h0014, 1'b0);
    run_i = 1'b1;
    wait_obs(0, 1'b1, 1000);
    rd_chk(8'h78, 16'h0000);
    run_i = 1'b0;
    wait_obs(0, 1'b0, 1000);
    rng("delay cycles", 40, 44);
    wait_obs(1, 1'b1, 100);
    rng("ramp start", 17, 18);
    i = n;
    wait_obs(2, 1'b1, 1000);
    n = n + i;
    rng("fall cycles", 76, 84);
    wait_obs(3, 1'b1, 300);
    rng("no warning", 300, 300);
    run_i = 1'b1;
    wait_obs(0, 1'b1, 1000);
    sink = 1'b0;
    stuck = 1'b1;
    ramp_seen = 1'b0;
    wr_chk(8'h66, 16'h0003, 1'b0);
    run_i = 1'b0;
    wait_obs(0, 1'b0, 1000);
    wait_obs(3, 1'b1, 100);
    rng("warn cycles", 56, 64);
    chk("ramp seen", 16'h0000, {15'h0000, ramp_seen});
    rd_chk(8'h79, 16'h8041);
    pulse_clear;
    rd_chk(8'h79, 16'h0040);
    $display("test turn_off done");
    give_verdict;
  end
endmodule
`default_nettype wire
